// >>> logic/sensor_host_ctrl.sv
// Host end: AXI4-Lite register slave that runs link transfers to the sensor.
// Assumes the sensor answers every link operation; one operation outstanding at a time.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "sensor_link_cfg.svh"

module sensor_host_ctrl
  import sensor_link_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  sensor_link_if.host link,
  output logic irq
);

  typedef enum {H_IDLE, H_START_W, H_WRITE, H_STOP_W, H_START_R, H_READ, H_STOP_R} host_state_t;

  // ==========================================
  // State
  host_state_t st_q, st_d;
  logic pend_q, pend_d;
  logic issue_q, issue_d;
  link_op_t kind_q, kind_d;
  logic [7:0] byte_q, byte_d;
  logic ack_q, ack_d;
  logic [2:0] idx_q, idx_d;
  logic [47:0] rbuf_q, rbuf_d;
  logic nack_q, nack_d;
  logic [18:0] cmd_q, cmd_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] rd0_q, rd0_d;
  logic [15:0] rd1_q, rd1_d;
  logic [2:0] ist_q, ist_d;
  logic [2:0] imask_q, imask_d;
  logic aw_q, aw_d;
  logic w_q, w_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [2:0] ev;
  logic go;
  logic [39:0] wseq;
  logic [2:0] nw;
  logic [2:0] nr;
  logic [31:0] rh_centi;
  logic [31:0] t_centi;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw_v, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = nw_v[i*8 +: 8];
    end
    return r;
  endfunction

  // Host bytes: command high first, then optional word and its checksum
  // Command-only sequences start at index 3, so the command sits in the low word
  assign wseq = cmd_q[`CMD_WITH_DATA] ? {cmd_q[15:0], wdata_q, crc8_word(wdata_q)} : {24'h000000, cmd_q[15:0]}; // R8 R9 R10
  assign nw = cmd_q[`CMD_WITH_DATA] ? `WR_BYTES_DATA : `WR_BYTES_CMD;
  assign nr = {cmd_q[18:17], 1'b0} + {1'b0, cmd_q[18:17]};
  // Exact scaling to hundredths; divider cost traded for software simplicity
  assign rh_centi = (32'(rd0_q) * `RH_SPAN) / `RAW_FULL; // R12
  assign t_centi = ((32'(rd1_q) * `T_SPAN) / `RAW_FULL) - `T_OFFSET; // R12

  // ==========================================
  // AXI4-Lite slave
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    cmd_d = cmd_q;
    wdata_d = wdata_q;
    imask_d = imask_q;
    go = 1'b0;
    ist_d = ist_q | ev;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `AXI_OKAY;
      unique case (awaddr_q)
        `REG_CTRL: go = ws_q[0] & wd_q[0];
        `REG_CMD: cmd_d = 19'(merge({13'h0000, cmd_q}, wd_q, ws_q));
        `REG_WDATA: wdata_d = 16'(merge({16'h0000, wdata_q}, wd_q, ws_q));
        `REG_INT_STATUS: ist_d = (ist_q & ~(wd_q[2:0] & {3{ws_q[0]}})) | ev; // Set beats clear
        `REG_INT_MASK: imask_d = 3'(merge({29'h00000000, imask_q}, wd_q, ws_q));
        default: bresp_d = `AXI_SLVERR;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) bvalid_d = 1'b0;
    if (s_axi_rvalid && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = `AXI_OKAY;
      unique case (s_axi_araddr)
        `REG_CTRL: rdata_d = {31'h00000000, st_q != H_IDLE};
        `REG_CMD: rdata_d = {13'h0000, cmd_q};
        `REG_WDATA: rdata_d = {16'h0000, wdata_q};
        `REG_RDATA0: rdata_d = {16'h0000, rd0_q};
        `REG_RDATA1: rdata_d = {16'h0000, rd1_q};
        `REG_INT_STATUS: rdata_d = {29'h00000000, ist_q};
        `REG_INT_MASK: rdata_d = {29'h00000000, imask_q};
        `REG_RH_CENTI: rdata_d = rh_centi;
        `REG_T_CENTI: rdata_d = t_centi;
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = `AXI_SLVERR;
        end
      endcase
    end
  end

  // ==========================================
  // Link sequencer
  always_comb begin
    st_d = st_q;
    pend_d = pend_q;
    issue_d = 1'b0;
    kind_d = kind_q;
    byte_d = byte_q;
    ack_d = ack_q;
    idx_d = idx_q;
    rbuf_d = rbuf_q;
    nack_d = nack_q;
    rd0_d = rd0_q;
    rd1_d = rd1_q;
    ev = 3'h0;
    if (st_q == H_IDLE) begin
      if (go) begin
        st_d = H_START_W;
        idx_d = 3'h0;
        nack_d = 1'b0;
      end
    end else if (!pend_q) begin
      pend_d = 1'b1;
      issue_d = 1'b1;
      byte_d = 8'h00;
      ack_d = 1'b0;
      unique case (st_q)
        H_START_W: begin
          kind_d = OP_START;
          byte_d = {`DEV_ADDR, 1'b0};
        end
        H_WRITE: begin
          kind_d = OP_WRITE;
          byte_d = 8'(wseq >> (8 * (3'h4 - idx_q)));
        end
        H_START_R: begin
          kind_d = OP_START;
          byte_d = {`DEV_ADDR, 1'b1};
        end
        H_READ: begin
          kind_d = OP_READ;
          ack_d = (idx_q != nr - 3'h1);
        end
        default: kind_d = OP_STOP;
      endcase
    end else if (link.rsp_valid) begin
      pend_d = 1'b0;
      unique case (st_q)
        H_START_W, H_WRITE, H_START_R: begin
          if (!link.rsp_ack) begin
            nack_d = 1'b1;
            st_d = H_STOP_R;
          end else if (st_q == H_START_R) begin
            st_d = H_READ;
            idx_d = 3'h0;
          end else if (st_q == H_START_W) begin
            st_d = H_WRITE;
            idx_d = 3'(5) - nw;
          end else begin
            idx_d = idx_q + 3'h1;
            if (idx_q == 3'h4) st_d = H_STOP_W;
          end
        end
        H_STOP_W: st_d = (nr == 3'h0) ? H_IDLE : H_START_R;
        H_READ: begin
          rbuf_d = {rbuf_q[39:0], link.rsp_byte};
          idx_d = idx_q + 3'h1;
          if (idx_q == nr - 3'h1) st_d = H_STOP_R;
        end
        default: st_d = H_IDLE;
      endcase
      if (st_d == H_IDLE) begin
        ev[`INT_DONE] = 1'b1;
        ev[`INT_NACK] = nack_q | nack_d;
        if (!nack_d && nr == 3'h3) begin
          rd0_d = rbuf_q[23:8];
          ev[`INT_CRC] = crc8_word(rbuf_q[23:8]) != rbuf_q[7:0]; // R8 R9 R10
        end else if (!nack_d && nr == 3'h6) begin
          rd0_d = rbuf_q[47:32];
          rd1_d = rbuf_q[23:8];
          ev[`INT_CRC] = (crc8_word(rbuf_q[47:32]) != rbuf_q[31:24]) | (crc8_word(rbuf_q[23:8]) != rbuf_q[7:0]);
        end
      end
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= H_IDLE;
      pend_q <= 1'b0;
      issue_q <= 1'b0;
      kind_q <= OP_STOP;
      byte_q <= 8'h00;
      ack_q <= 1'b0;
      idx_q <= 3'h0;
      rbuf_q <= 48'h000000000000;
      nack_q <= 1'b0;
      cmd_q <= 19'h00000;
      wdata_q <= 16'h0000;
      rd0_q <= 16'h0000;
      rd1_q <= 16'h0000;
      ist_q <= 3'h0;
      imask_q <= 3'h0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else begin
      st_q <= st_d;
      pend_q <= pend_d;
      issue_q <= issue_d;
      kind_q <= kind_d;
      byte_q <= byte_d;
      ack_q <= ack_d;
      idx_q <= idx_d;
      rbuf_q <= rbuf_d;
      nack_q <= nack_d;
      cmd_q <= cmd_d;
      wdata_q <= wdata_d;
      rd0_q <= rd0_d;
      rd1_q <= rd1_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ==========================================
  // Outputs
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign link.cmd_valid = issue_q;
  assign link.cmd_kind = kind_q;
  assign link.cmd_byte = byte_q;
  assign link.cmd_ack = ack_q;
  assign irq = |(ist_q & imask_q);

endmodule // sensor_host_ctrl

// >>> logic/sensor_link_cfg.svh
// Named constants for the sensor status link: commands, status bits, checksum and host registers.
// Assumes inclusion by bare name; macros are global to the compilation unit.
`ifndef SENSOR_LINK_CFG_SVH
`define SENSOR_LINK_CFG_SVH

// ==========================================
// Link addressing and command words
`define DEV_ADDR 7'h45
`define CMD_READ_STATUS 16'hF32D
`define CMD_CLEAR_STATUS 16'h3041
`define CMD_SOFT_RESET 16'h30A2
`define CMD_FETCH 16'hE000
`define CMD_WRITE_WORD 16'h6100
`define WR_BYTES_CMD 3'h2
`define WR_BYTES_DATA 3'h5

// ==========================================
// Checksum
`define CRC_POLY 8'h31
`define CRC_INIT 8'hFF
`define CRC_XOUT 8'h00
`define TX_FILL 8'hFF

// ==========================================
// Status word bit positions and reset values
`define ST_ALERT 15
`define ST_HEATER 13
`define ST_RH_ALERT 11
`define ST_T_ALERT 10
`define ST_RESET 4
`define ST_CMD_ERR 1
`define ST_CRC_ERR 0
`define ST_ALERT_RST 1'h1
`define ST_RESET_RST 1'h1

// ==========================================
// Host register byte offsets and fields
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA0 8'h0C
`define REG_RDATA1 8'h10
`define REG_INT_STATUS 8'h14
`define REG_INT_MASK 8'h18
`define REG_RH_CENTI 8'h1C
`define REG_T_CENTI 8'h20
`define CMD_WITH_DATA 16
`define INT_DONE 0
`define INT_NACK 1
`define INT_CRC 2
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

// ==========================================
// Host scaling, results in hundredths
`define RAW_FULL 32'h0000FFFF
`define RH_SPAN 32'h00002710
`define T_SPAN 32'h0000445C
`define T_OFFSET 32'h00001194

`endif

// >>> logic/sensor_link_if.sv
// Byte-level link between the host controller and the sensor end.
// Assumes both ends run on the same clock; one operation outstanding at a time.
`timescale 1ns/1ps

interface sensor_link_if;
  logic cmd_valid;
  sensor_link_pkg::link_op_t cmd_kind;
  logic [7:0] cmd_byte;
  logic cmd_ack;
  logic rsp_valid;
  logic [7:0] rsp_byte;
  logic rsp_ack;

  modport host (output cmd_valid, output cmd_kind, output cmd_byte, output cmd_ack,
                input rsp_valid, input rsp_byte, input rsp_ack);
  modport device (input cmd_valid, input cmd_kind, input cmd_byte, input cmd_ack,
                  output rsp_valid, output rsp_byte, output rsp_ack);
endinterface // sensor_link_if

// >>> logic/sensor_link_pkg.sv
// Types and the checksum function shared by both ends of the sensor link.
// Assumes the constants header is on the include path.
`include "sensor_link_cfg.svh"

package sensor_link_pkg;

  // ==========================================
  // Link operations
  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} link_op_t;

  // ==========================================
  // Checksum over one word, high byte first
  function automatic logic [7:0] crc8_word(input logic [15:0] w);
    logic [7:0] c;
    c = `CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
    end
    return c ^ `CRC_XOUT;
  endfunction

endpackage

// >>> logic/sensor_status_device.sv
// Sensor end: status word, command decode, checksums, result words.
// Assumes the host issues one link operation and waits for the answer.
`timescale 1ns/1ps
`include "sensor_link_cfg.svh"

// Behaviour
// R1 - Bit 15 flags pending alerts, reset one
// R2 - Bit 13 follows heater state
// R3 - Bits 11, 10 flag humidity, temperature alerts
// R4 - Bit 4 set by any reset
// R5 - Bit 1 flags rejected last command
// R6 - Bit 0 flags bad write checksum
// R7 - Clear command zeroes bits 15, 11, 10, 4
// R8 - Checksum byte follows every data word
// R9 - Checksum covers two preceding bytes only
// R10 - Polynomial 0x31, init 0xFF, no reflection
// R11 - Results are sixteen bit unsigned words
// R12 - Host scales humidity and temperature raw words
// R13 - Reserved status bits read zero
// R14 - Status read: word high first, then checksum
module sensor_status_device
  import sensor_link_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sensor_link_if.device link,
  input wire logic alert_rh,
  input wire logic alert_t,
  input wire logic heater_on,
  input wire logic reset_event,
  input wire logic [15:0] raw_humidity_word,
  input wire logic [15:0] raw_temperature_word,
  output logic [15:0] written_word,
  output logic written_valid,
  output logic [15:0] status_word
);

  // ==========================================
  // State
  logic sel_q, sel_d;
  logic rd_q, rd_d;
  logic [2:0] wcnt_q, wcnt_d;
  logic [39:0] wbuf_q, wbuf_d;
  logic [47:0] tx_q, tx_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [7:0] rsp_byte_q, rsp_byte_d;
  logic rsp_ack_q, rsp_ack_d;
  logic alert_q, alert_d;
  logic rh_alert_q, rh_alert_d;
  logic t_alert_q, t_alert_d;
  logic reset_q, reset_d;
  logic cmd_err_q, cmd_err_d;
  logic crc_err_q, crc_err_d;
  logic [15:0] written_q, written_d;
  logic written_valid_q, written_valid_d;
  logic clear_cmd;
  logic soft_cmd;
  logic [15:0] cmd_word;
  logic [15:0] data_word;

  // ==========================================
  // Status word assembly
  always_comb begin
    status_word = 16'h0000; // R13
    status_word[`ST_ALERT] = alert_q; // R1
    status_word[`ST_HEATER] = heater_on; // R2
    status_word[`ST_RH_ALERT] = rh_alert_q; // R3
    status_word[`ST_T_ALERT] = t_alert_q; // R3
    status_word[`ST_RESET] = reset_q; // R4
    status_word[`ST_CMD_ERR] = cmd_err_q; // R5
    status_word[`ST_CRC_ERR] = crc_err_q; // R6
  end

  assign cmd_word = (wcnt_q == `WR_BYTES_DATA) ? wbuf_q[39:24] : wbuf_q[15:0];
  assign data_word = wbuf_q[23:8];

  // ==========================================
  // Link decode and command execution
  always_comb begin
    sel_d = sel_q;
    rd_d = rd_q;
    wcnt_d = wcnt_q;
    wbuf_d = wbuf_q;
    tx_d = tx_q;
    rsp_valid_d = 1'b0;
    rsp_byte_d = rsp_byte_q;
    rsp_ack_d = 1'b0;
    cmd_err_d = cmd_err_q;
    crc_err_d = crc_err_q;
    written_d = written_q;
    written_valid_d = 1'b0;
    clear_cmd = 1'b0;
    soft_cmd = 1'b0;
    if (link.cmd_valid) begin
      rsp_valid_d = 1'b1;
      unique case (link.cmd_kind)
        OP_START: begin
          sel_d = (link.cmd_byte[7:1] == `DEV_ADDR);
          rd_d = link.cmd_byte[0];
          wcnt_d = 3'h0;
          rsp_ack_d = (link.cmd_byte[7:1] == `DEV_ADDR);
        end
        OP_WRITE: begin
          // Extra bytes beyond the command, one word and its checksum are refused
          if (sel_q && !rd_q && (wcnt_q < `WR_BYTES_DATA)) begin
            wbuf_d = {wbuf_q[31:0], link.cmd_byte};
            wcnt_d = wcnt_q + 3'h1;
            rsp_ack_d = 1'b1;
          end
        end
        OP_READ: begin
          // Bytes past the loaded words read as fill
          if (sel_q && rd_q) begin
            rsp_byte_d = tx_q[47:40];
            tx_d = {tx_q[39:0], `TX_FILL};
            rsp_ack_d = 1'b1;
          end
        end
        OP_STOP: begin
          rsp_ack_d = 1'b1;
          sel_d = 1'b0;
          if (sel_q && !rd_q) begin
            if (wcnt_q == `WR_BYTES_CMD) begin
              cmd_err_d = 1'b0; // R5
              if (cmd_word == `CMD_CLEAR_STATUS) begin
                clear_cmd = 1'b1; // R7
              end else if (cmd_word == `CMD_SOFT_RESET) begin
                soft_cmd = 1'b1; // R4
              end else if (cmd_word == `CMD_READ_STATUS) begin
                tx_d = {status_word, crc8_word(status_word), {3{`TX_FILL}}}; // R14 R8
              end else if (cmd_word == `CMD_FETCH) begin
                tx_d = {raw_humidity_word, crc8_word(raw_humidity_word),
                        raw_temperature_word, crc8_word(raw_temperature_word)}; // R11 R8 R9
              end else begin
                cmd_err_d = 1'b1; // R5
              end
            end else if ((wcnt_q == `WR_BYTES_DATA) && (cmd_word == `CMD_WRITE_WORD)) begin
              cmd_err_d = 1'b0; // R5
              crc_err_d = (crc8_word(data_word) != wbuf_q[7:0]); // R6 R9 R10
              if (crc8_word(data_word) == wbuf_q[7:0]) begin
                written_d = data_word;
                written_valid_d = 1'b1;
              end
            end else begin
              cmd_err_d = 1'b1; // R5
            end
          end
        end
      endcase
    end
  end

  // ==========================================
  // Sticky flags; a new event beats a same-cycle clear
  always_comb begin
    alert_d = (alert_q & ~clear_cmd) | alert_rh | alert_t; // R1 R7
    rh_alert_d = (rh_alert_q & ~clear_cmd) | alert_rh; // R3 R7
    t_alert_d = (t_alert_q & ~clear_cmd) | alert_t; // R3 R7
    reset_d = (reset_q & ~clear_cmd) | reset_event | soft_cmd; // R4 R7
  end

  // ==========================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= 1'b0;
      rd_q <= 1'b0;
      wcnt_q <= 3'h0;
      wbuf_q <= 40'h0000000000;
      tx_q <= 48'hFFFFFFFFFFFF;
      rsp_valid_q <= 1'b0;
      rsp_byte_q <= 8'h00;
      rsp_ack_q <= 1'b0;
      alert_q <= `ST_ALERT_RST; // R1
      rh_alert_q <= 1'b0;
      t_alert_q <= 1'b0;
      reset_q <= `ST_RESET_RST; // R4
      cmd_err_q <= 1'b0;
      crc_err_q <= 1'b0;
      written_q <= 16'h0000;
      written_valid_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      rd_q <= rd_d;
      wcnt_q <= wcnt_d;
      wbuf_q <= wbuf_d;
      tx_q <= tx_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_byte_q <= rsp_byte_d;
      rsp_ack_q <= rsp_ack_d;
      alert_q <= alert_d;
      rh_alert_q <= rh_alert_d;
      t_alert_q <= t_alert_d;
      reset_q <= reset_d;
      cmd_err_q <= cmd_err_d;
      crc_err_q <= crc_err_d;
      written_q <= written_d;
      written_valid_q <= written_valid_d;
    end
  end

  // ==========================================
  // Outputs
  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_byte = rsp_byte_q;
  assign link.rsp_ack = rsp_ack_q;
  assign written_word = written_q;
  assign written_valid = written_valid_q;

endmodule // sensor_status_device

// >>> verification/sensor_link_assertions.sv
// Checker for the byte link between host controller and sensor end.
// Assumes one clock; takes the interface signals as plain inputs.
`timescale 1ns/1ps

module sensor_link_assertions
  import sensor_link_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_valid,
  input wire link_op_t cmd_kind,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_ack,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_ack
);
  // ==========================================
  // Read byte tracking
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] cnt_q, cnt_d;
  logic [15:0] hist_q, hist_d;
  link_op_t kind_q, kind_d;

  // Own copy, so a shared slip cannot hide
  function automatic logic [7:0] crc_ref(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'h0} ^ 8'h31) : {c[6:0], 1'h0};
    end
    return c;
  endfunction

  always_comb begin
    cnt_d = cnt_q;
    hist_d = hist_q;
    kind_d = cmd_valid ? cmd_kind : kind_q;
    if (cmd_valid && cmd_kind == OP_START) begin
      cnt_d = 2'h0;
    end
    if (rsp_valid && kind_q == OP_READ) begin
      cnt_d = (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      hist_d = {hist_q[7:0], rsp_byte};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 2'h0;
      hist_q <= 16'h0000;
      kind_q <= OP_STOP;
    end else begin
      cnt_q <= cnt_d;
      hist_q <= hist_d;
      kind_q <= kind_d;
    end
  end

  // ==========================================
  // Properties
  answer_one_cycle_a: assert property (cmd_valid |=> rsp_valid) else $error("no answer after op");
  answer_has_cause_a: assert property (rsp_valid |-> $past(cmd_valid)) else $error("answer without op");
  single_op_a: assert property (cmd_valid |=> !cmd_valid) else $error("ops too close");
  op_byte_zero_a: assert property (cmd_valid && (cmd_kind == OP_READ || cmd_kind == OP_STOP) |->
    cmd_byte == 8'h00) else $error("read or stop carries a byte");
  idle_byte_hold_a: assert property (rsp_valid && kind_q != OP_READ |-> $stable(rsp_byte))
    else $error("answer byte moved");
  word_crc_a: assert property (rsp_valid && kind_q == OP_READ && cnt_q == 2'h2 |->
    rsp_byte == crc_ref(hist_q)) else $error("bad word checksum");
  start_acked_a: assert property (rsp_valid && kind_q == OP_START |-> rsp_ack) else $error("start refused");
  reset_idle_a: assert property (disable iff (1'h0) !aresetn |=> !cmd_valid && !rsp_valid)
    else $error("link busy in reset");
  cover property (rsp_valid && kind_q == OP_READ && cnt_q == 2'h2);
  cover property (cmd_valid && cmd_kind == OP_START);
  cover property (cmd_valid && cmd_kind == OP_STOP);
endmodule // sensor_link_assertions

// >>> verification/sensor_status_and_crc_bench.sv
// Bench: host controller and sensor end joined by the link, driven over AXI4-Lite.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/1ps
`include "sensor_link_cfg.svh"

module sensor_status_and_crc_bench;
  // ==========================================
  // Signals and instances
  typedef struct {logic [15:0] h; logic [15:0] t; logic [31:0] rh; logic [31:0] tc;} row_t;
  row_t rows[3] = '{'{16'h0000, 16'h0000, 32'h0, 32'hFFFFEE6C}, '{16'hFFFF, 16'hFFFF, 32'h2710, 32'h32C8},
    '{16'h8000, 16'h6666, 32'h1388, 32'h09C4}};
  logic aclk, aresetn, alert_rh, alert_t, heater_on, reset_event, written_valid, irq;
  logic [15:0] raw_humidity_word, raw_temperature_word, written_word, status_word, seen_word, s;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int n_errors = 0;
  int samples_checked = 0;

  sensor_link_if sensor_link_if_inst();
  sensor_status_device sensor_status_device_inst (.aclk(aclk), .aresetn(aresetn), .link(sensor_link_if_inst),
    .alert_rh(alert_rh), .alert_t(alert_t), .heater_on(heater_on), .reset_event(reset_event),
    .raw_humidity_word(raw_humidity_word), .raw_temperature_word(raw_temperature_word),
    .written_word(written_word), .written_valid(written_valid), .status_word(status_word));
  sensor_host_ctrl sensor_host_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(sensor_link_if_inst), .irq(irq));
  sensor_link_assertions sensor_link_assertions_inst (.aclk(aclk), .aresetn(aresetn),
    .cmd_valid(sensor_link_if_inst.cmd_valid), .cmd_kind(sensor_link_if_inst.cmd_kind),
    .cmd_byte(sensor_link_if_inst.cmd_byte), .cmd_ack(sensor_link_if_inst.cmd_ack),
    .rsp_valid(sensor_link_if_inst.rsp_valid), .rsp_byte(sensor_link_if_inst.rsp_byte),
    .rsp_ack(sensor_link_if_inst.rsp_ack));

  always #10 aclk = ~aclk;
  always @(posedge aclk) if (written_valid) seen_word <= written_word;

  // ==========================================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'h0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask

  // Busy poll bounded; the watchdog covers a stuck link
  task op(input logic [31:0] c);
    int k;
    wr(`REG_CMD, c, r);
    wr(`REG_CTRL, 32'h1, r);
    k = 0;
    do begin
      rd(`REG_CTRL, d, r);
      k++;
    end while (d[0] !== 1'h0 && k < 200);
  endtask

  task pulse_chk(input logic [15:0] exp);
    @(posedge aclk);
    alert_rh <= 1'h0;
    alert_t <= 1'h0;
    reset_event <= 1'h0;
    @(posedge aclk);
    chk(status_word, exp);
  endtask

  task finish_test;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // Sequence
  initial begin
    #(20 * 40000);
    n_errors++;
    finish_test();
  end

  initial begin
    {aclk, aresetn, alert_rh, alert_t, heater_on, reset_event, awvalid, wvalid, bready} = 9'h0;
    {arvalid, rready, raw_humidity_word, raw_temperature_word, seen_word} = 50'h0;
    {awaddr, araddr, wdata, wstrb} = 52'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(status_word, 16'h8010);
    foreach (rows[i]) begin
      raw_humidity_word <= rows[i].h;
      raw_temperature_word <= rows[i].t;
      op(32'h0004E000);
      rd(`REG_RDATA0, d, r);
      chk(d, {16'h0, rows[i].h});
      rd(`REG_RDATA1, d, r);
      chk(d, {16'h0, rows[i].t});
      rd(`REG_RH_CENTI, d, r);
      chk(d, rows[i].rh);
      rd(`REG_T_CENTI, d, r);
      chk(d, rows[i].tc);
    end
    heater_on <= 1'h1;
    op(32'h0002F32D);
    rd(`REG_RDATA0, d, r);
    chk(d, 32'hA010);
    heater_on <= 1'h0;
    op(32'h3041);
    chk(status_word, 16'h0000);
    alert_rh <= 1'h1;
    pulse_chk(16'h8800);
    alert_t <= 1'h1;
    pulse_chk(16'h8C00);
    op(32'h1234);
    chk(status_word, 16'h8C02);
    reset_event <= 1'h1;
    pulse_chk(16'h8C12);
    op(32'h3041);
    chk(status_word, 16'h0000);
    rd(`REG_INT_STATUS, d, r);
    chk(d[0], 1'h1);
    chk(irq, 1'h0);
    wr(`REG_INT_MASK, 32'h1, r);
    chk(irq, 1'h1);
    wr(`REG_INT_STATUS, 32'h7, r);
    chk(irq, 1'h0);
    wr(`REG_WDATA, 32'hBEEF, r);
    op(32'h00016100);
    chk(seen_word, 16'hBEEF);
    chk(status_word, 16'h0000);
    op(32'h30A2);
    chk(status_word, 16'h0010);
    wr(8'h40, 32'h1, r);
    chk(r, `AXI_SLVERR);
    rd(8'h40, d, r);
    chk(d, 32'h00000000);
    chk(r, `AXI_SLVERR);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(status_word, 16'h8010);
    finish_test();
  end
endmodule // sensor_status_and_crc_bench
